// File: design/oprf_pkg.sv
// shared sizes, codes and helpers of the operand register file
package oprf_pkg;
  localparam int unsigned OPRF_DATA_W = 32;
  localparam int unsigned OPRF_WORD_W = 16;
  localparam int unsigned OPRF_BYTE_W = 8;
  localparam int unsigned OPRF_NREG = 16;
  localparam int unsigned OPRF_ADDR_W = 24;
  localparam int unsigned OPRF_AREG_BIT = 3;
  localparam logic [3:0] OPRF_SP_IDX = 4'hf;
  localparam logic [2:0] OPRF_EA_AREG = 3'h1;
  localparam logic [3:0] OPRF_BE_BYTE = 4'h1;
  localparam logic [3:0] OPRF_BE_WORD = 4'h3;
  localparam logic [3:0] OPRF_BE_LONG = 4'hf;
  localparam logic [15:0] OPRF_LOOP_END = 16'hffff;
  localparam logic [3:0] OPRF_BCD_MAX = 4'h9;
  localparam logic [23:0] OPRF_WORD_STEP = 24'h000002;
  localparam logic OPRF_RST_READY = 1'b1;
  typedef enum logic [1:0] {
    OPRF_SZ_BYTE = 2'h0,
    OPRF_SZ_WORD = 2'h1,
    OPRF_SZ_LONG = 2'h2,
    OPRF_SZ_BAD = 2'h3
  } oprf_size_t;
  typedef enum logic [2:0] {
    OPRF_OP_READ, OPRF_OP_WRITE, OPRF_OP_QUICK, OPRF_OP_LOOP,
    OPRF_OP_BCD, OPRF_OP_MRD, OPRF_OP_MWR, OPRF_OP_NOP
  } oprf_op_t;
  typedef enum logic [1:0] {OPRF_LOC_FIELD, OPRF_LOC_EA, OPRF_LOC_IMPL} oprf_loc_t;
endpackage

// File: design/oprf_link_if.sv
// links between the core, its register memory and its bus sequencer
`timescale 1ns/1ps
interface oprf_link_if;
  import oprf_pkg::*;
  logic rf_we;
  logic [3:0] rf_widx;
  logic [3:0] rf_be;
  logic [31:0] rf_wdata;
  logic [3:0] rf_ridx;
  logic [31:0] rf_rdata;
  logic bs_go;
  logic bs_we;
  oprf_size_t bs_size;
  logic [23:0] bs_addr;
  logic [31:0] bs_wdata;
  logic bs_done;
  logic bs_err;
  logic [31:0] bs_rdata;
  modport rf_user(output rf_we, rf_widx, rf_be, rf_wdata, rf_ridx, input rf_rdata);
  modport rf_mem(input rf_we, rf_widx, rf_be, rf_wdata, rf_ridx, output rf_rdata);
  modport bs_user(output bs_go, bs_we, bs_size, bs_addr, bs_wdata, input bs_done, bs_err, bs_rdata);
  modport bs_seq(input bs_go, bs_we, bs_size, bs_addr, bs_wdata, output bs_done, bs_err, bs_rdata);
endinterface

// File: design/oprf_regmem.sv
// sixteen 32-bit registers with byte-lane writes and a registered read
`timescale 1ns/1ps
module oprf_regmem (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  oprf_link_if.rf_mem rf
);
  import oprf_pkg::*;
  typedef struct packed {
    logic [OPRF_NREG-1:0][OPRF_DATA_W-1:0] regs;
    logic [OPRF_DATA_W-1:0] rd;
  } oprf_mem_st_t;
  oprf_mem_st_t m_reg, m_next;

  // eight data plus eight address words
  always_comb begin
    m_next = m_reg;
    m_next.rd = m_reg.regs[rf.rf_ridx];
    for (int b = 0; b < 4; b++) begin
      // unselected lanes keep their old bits
      if (rf.rf_we && rf.rf_be[b]) begin
        m_next.regs[rf.rf_widx][b*8 +: 8] = rf.rf_wdata[b*8 +: 8];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      m_reg <= '0;
    end else begin
      m_reg <= m_next;
    end
  end

  assign rf.rf_rdata = m_reg.rd;
endmodule

// File: design/oprf_bus_seq.sv
// splits sized memory accesses into big-endian word beats with strobes
`timescale 1ns/1ps
module oprf_bus_seq (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  oprf_link_if.bs_seq bs,
  input wire logic mem_ack_in,
  input wire logic [15:0] mem_rdata_in,
  output logic mem_req_out,
  output logic mem_we_out,
  output logic [23:0] mem_addr_out,
  output logic upper_byte_strobe_out,
  output logic lower_byte_strobe_out,
  output logic [15:0] mem_wdata_out
);
  import oprf_pkg::*;
  typedef enum logic [1:0] {OPRF_BS_IDLE = 2'h0, OPRF_BS_HI = 2'h1, OPRF_BS_LO = 2'h3} oprf_bs_state_t;
  typedef struct packed {
    oprf_bs_state_t st;
    oprf_size_t size;
    logic we;
    logic req;
    logic upper_byte_strobe;
    logic lower_byte_strobe;
    logic [23:0] addr;
    logic [31:0] wdata;
    logic [15:0] mdata;
    logic [31:0] rdata;
    logic done;
    logic err;
  } oprf_bs_st_t;
  oprf_bs_st_t s_reg, s_next;

  // beat sequencing, high word first
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.err = 1'b0;
    case (s_reg.st)
      OPRF_BS_IDLE: begin
        if (bs.bs_go) begin
          s_next.size = bs.bs_size;
          s_next.we = bs.bs_we;
          s_next.wdata = bs.bs_wdata;
          s_next.rdata = 32'h0;
          if (bs.bs_addr[0] && bs.bs_size != OPRF_SZ_BYTE) begin
            s_next.err = 1'b1;
            s_next.done = 1'b1;
          end else begin
            s_next.req = 1'b1;
            s_next.st = OPRF_BS_HI;
            s_next.addr = {bs.bs_addr[23:1], 1'b0};
            // lane strobes, even byte is upper
            s_next.upper_byte_strobe = (bs.bs_size != OPRF_SZ_BYTE) || !bs.bs_addr[0];
            s_next.lower_byte_strobe = (bs.bs_size != OPRF_SZ_BYTE) || bs.bs_addr[0];
            case (bs.bs_size)
              OPRF_SZ_LONG: s_next.mdata = bs.bs_wdata[31:16];
              OPRF_SZ_WORD: s_next.mdata = bs.bs_wdata[15:0];
              default: s_next.mdata = {2{bs.bs_wdata[7:0]}};
            endcase
          end
        end
      end
      OPRF_BS_HI: begin
        if (mem_ack_in) begin
          // long word: second word at n plus two
          if (s_reg.size == OPRF_SZ_LONG) begin
            s_next.rdata[31:16] = mem_rdata_in;
            s_next.st = OPRF_BS_LO;
            s_next.addr = s_reg.addr + OPRF_WORD_STEP;
            s_next.mdata = s_reg.wdata[15:0];
          end else begin
            // upper lane holds the even byte
            if (s_reg.size == OPRF_SZ_WORD) begin
              s_next.rdata = {16'h0, mem_rdata_in};
            end else begin
              s_next.rdata = {24'h0, s_reg.upper_byte_strobe ? mem_rdata_in[15:8] : mem_rdata_in[7:0]};
            end
            // single beat done, release the bus
            s_next.st = OPRF_BS_IDLE;
            s_next.req = 1'b0;
            s_next.upper_byte_strobe = 1'b0;
            s_next.lower_byte_strobe = 1'b0;
            s_next.done = 1'b1;
          end
        end
      end
      OPRF_BS_LO: begin
        if (mem_ack_in) begin
          s_next.rdata[15:0] = mem_rdata_in;
          // low word taken, release the bus
          s_next.st = OPRF_BS_IDLE;
          s_next.req = 1'b0;
          s_next.upper_byte_strobe = 1'b0;
          s_next.lower_byte_strobe = 1'b0;
          s_next.done = 1'b1;
        end
      end
      default: s_next.st = OPRF_BS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign mem_req_out = s_reg.req;
  assign mem_we_out = s_reg.we;
  assign mem_addr_out = s_reg.addr;
  assign upper_byte_strobe_out = s_reg.upper_byte_strobe;
  assign lower_byte_strobe_out = s_reg.lower_byte_strobe;
  assign mem_wdata_out = s_reg.mdata;
  assign bs.bs_done = s_reg.done;
  assign bs.bs_err = s_reg.err;
  assign bs.bs_rdata = s_reg.rdata;
endmodule

// File: design/oprf_core.sv
// sized operand register file core with loop, quick load and memory ops
`timescale 1ns/1ps
// Overview of operation
// - byte is 8 bits, word 16 bits, long word 32 bits
// - explicit sizes take byte, word or long; implicit ops use fixed subset
// - eight 32-bit data registers with byte, word, long access
// - byte in bits 7..0, word in 15..0, long fills all 32
// - bit zero is least significant, bit 31 most significant
// - sized data register writes change only the low portion
// - seven address registers plus stack pointer, each full 32 bits
// - address registers refuse byte size
// - address source gives low word or whole long by size
// - address register destination always written in full
// - word writes to address registers sign-extend operands to 32 bits
// - memory big-endian: high byte at even address, low byte odd
// - fetches and multi-byte data only at even addresses
// - long at n moves as two words, high at n, low at n+2
// - packed decimal: two digits per byte, top digit upper nibble
// - quick load sign-extends an 8-bit immediate into a data register
// - loop op tests condition, decrements counter and branches at once
// - operand found by register field, effective address or implication
// - bus has separate upper and lower byte strobes
// - odd word or long access raises address error instead
module oprf_core (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic cmd_valid_in,
  input wire oprf_pkg::oprf_op_t cmd_op_in,
  input wire oprf_pkg::oprf_size_t cmd_size_in,
  input wire oprf_pkg::oprf_loc_t cmd_loc_in,
  input wire logic [3:0] cmd_reg_in,
  input wire logic [5:0] cmd_ea_in,
  input wire logic [31:0] cmd_data_in,
  input wire logic [23:0] cmd_addr_in,
  input wire logic cmd_cond_in,
  input wire logic mem_ack_in,
  input wire logic [15:0] mem_rdata_in,
  output logic cmd_ready_out,
  output logic rsp_valid_out,
  output logic [31:0] rsp_data_out,
  output logic size_err_out,
  output logic addr_err_out,
  output logic branch_out,
  output logic [3:0] top_decimal_digit_out,
  output logic [3:0] bottom_decimal_digit_out,
  output logic digit_err_out,
  output logic mem_req_out,
  output logic mem_we_out,
  output logic [23:0] mem_addr_out,
  output logic upper_byte_strobe_out,
  output logic lower_byte_strobe_out,
  output logic [15:0] mem_wdata_out
);
  import oprf_pkg::*;

  typedef enum logic [1:0] {
    OPRF_ST_IDLE = 2'h0,
    OPRF_ST_RD = 2'h1,
    OPRF_ST_MEM = 2'h3
  } oprf_core_state_t;

  typedef struct packed {
    oprf_core_state_t st;
    oprf_op_t op;
    oprf_size_t size;
    logic [3:0] idx;
    logic cond;
    logic ready;
    logic rsp_valid;
    logic [31:0] rsp_data;
    logic size_err;
    logic addr_err;
    logic branch;
    logic [3:0] top_dig;
    logic [3:0] bot_dig;
    logic digit_err;
  } oprf_core_st_t;

  oprf_core_st_t st_reg, st_next;
  oprf_link_if link ();

  // register field, ea mode or implied pointer
  function automatic logic [3:0] oprf_locate(input oprf_loc_t loc, input logic [3:0] rnum,
                                              input logic [5:0] ea);
    logic [3:0] r;
    case (loc)
      OPRF_LOC_EA: r = {ea[5:3] == OPRF_EA_AREG, ea[2:0]};
      OPRF_LOC_IMPL: r = OPRF_SP_IDX;
      default: r = rnum;
    endcase
    return r;
  endfunction

  function automatic logic [3:0] oprf_be(input oprf_size_t sz);
    case (sz)
      OPRF_SZ_BYTE: return OPRF_BE_BYTE;
      OPRF_SZ_WORD: return OPRF_BE_WORD;
      default: return OPRF_BE_LONG;
    endcase
  endfunction

  // low bits from bit zero upward
  function automatic logic [31:0] oprf_mask(input logic [31:0] d, input oprf_size_t sz);
    case (sz)
      OPRF_SZ_BYTE: return {24'h0, d[OPRF_BYTE_W-1:0]};
      OPRF_SZ_WORD: return {16'h0, d[OPRF_WORD_W-1:0]};
      default: return d;
    endcase
  endfunction

  // sign extension from word or byte to a full long
  function automatic logic [31:0] oprf_sext16(input logic [15:0] w);
    return {{16{w[15]}}, w};
  endfunction

  function automatic logic [31:0] oprf_sext8(input logic [7:0] b);
    return {{24{b[7]}}, b};
  endfunction

  logic [3:0] cmd_idx;
  logic cmd_fire;
  logic cmd_areg;
  logic cmd_bad;
  logic [15:0] loop_cnt;
  logic [31:0] rd_data;

  // command decode, taken only while ready
  assign cmd_idx = oprf_locate(cmd_loc_in, cmd_reg_in, cmd_ea_in);
  assign cmd_fire = cmd_valid_in && st_reg.ready;
  assign cmd_areg = cmd_idx[OPRF_AREG_BIT];
  assign rd_data = link.rf_rdata;
  assign loop_cnt = rd_data[15:0] - 16'h0001;

  // refuse sizes that the target cannot take
  always_comb begin
    cmd_bad = (cmd_size_in == OPRF_SZ_BAD);
    case (cmd_op_in)
      // no byte operations on address registers
      OPRF_OP_READ, OPRF_OP_WRITE: cmd_bad = cmd_bad || (cmd_areg && cmd_size_in == OPRF_SZ_BYTE);
      // implicit-size ops ignore the size field
      OPRF_OP_QUICK, OPRF_OP_LOOP, OPRF_OP_BCD: cmd_bad = cmd_areg;
      OPRF_OP_NOP: cmd_bad = 1'b0;
      default: cmd_bad = cmd_bad;
    endcase
  end

  // one command at a time; pulses last a single cycle
  always_comb begin
    st_next = st_reg;
    st_next.rsp_valid = 1'b0;
    st_next.size_err = 1'b0;
    st_next.addr_err = 1'b0;
    link.rf_we = 1'b0;
    link.rf_widx = cmd_idx;
    link.rf_be = OPRF_BE_LONG;
    link.rf_wdata = cmd_data_in;
    link.rf_ridx = cmd_idx;
    link.bs_go = 1'b0;
    link.bs_we = (cmd_op_in == OPRF_OP_MWR);
    link.bs_size = cmd_size_in;
    link.bs_addr = cmd_addr_in;
    link.bs_wdata = cmd_data_in;
    case (st_reg.st)
      OPRF_ST_IDLE: begin
        if (cmd_fire) begin
          st_next.op = cmd_op_in;
          st_next.size = cmd_size_in;
          st_next.idx = cmd_idx;
          st_next.cond = cmd_cond_in;
          st_next.branch = 1'b0;
          st_next.digit_err = 1'b0;
          if (cmd_bad) begin
            st_next.size_err = 1'b1;
            st_next.rsp_valid = 1'b1;
            st_next.rsp_data = 32'h0;
          end else begin
            case (cmd_op_in)
              OPRF_OP_WRITE: begin
                link.rf_we = 1'b1;
                if (cmd_areg) begin
                  if (cmd_size_in == OPRF_SZ_WORD) begin
                    link.rf_wdata = oprf_sext16(cmd_data_in[15:0]);
                  end
                  st_next.rsp_data = link.rf_wdata;
                end else begin
                  // only low lanes of a data register
                  link.rf_be = oprf_be(cmd_size_in);
                  st_next.rsp_data = oprf_mask(cmd_data_in, cmd_size_in);
                end
                st_next.rsp_valid = 1'b1;
              end
              OPRF_OP_QUICK: begin
                // signed byte immediate to a long
                link.rf_we = 1'b1;
                link.rf_wdata = oprf_sext8(cmd_data_in[7:0]);
                st_next.rsp_data = link.rf_wdata;
                st_next.rsp_valid = 1'b1;
              end
              OPRF_OP_READ, OPRF_OP_LOOP, OPRF_OP_BCD: begin
                st_next.st = OPRF_ST_RD;
                st_next.ready = 1'b0;
              end
              OPRF_OP_MRD, OPRF_OP_MWR: begin
                link.bs_go = 1'b1;
                st_next.st = OPRF_ST_MEM;
                st_next.ready = 1'b0;
              end
              default: begin
                st_next.rsp_valid = 1'b1;
                st_next.rsp_data = 32'h0;
              end
            endcase
          end
        end
      end
      OPRF_ST_RD: begin
        // register read data is valid in this cycle
        st_next.st = OPRF_ST_IDLE;
        st_next.ready = 1'b1;
        st_next.rsp_valid = 1'b1;
        link.rf_widx = st_reg.idx;
        link.rf_be = OPRF_BE_WORD;
        link.rf_wdata = {16'h0, loop_cnt};
        case (st_reg.op)
          OPRF_OP_LOOP: begin
            if (st_reg.cond) begin
              st_next.branch = 1'b0;
              st_next.rsp_data = oprf_mask(rd_data, OPRF_SZ_WORD);
            end else begin
              link.rf_we = 1'b1;
              st_next.branch = (loop_cnt != OPRF_LOOP_END);
              st_next.rsp_data = {16'h0, loop_cnt};
            end
          end
          OPRF_OP_BCD: begin
            st_next.top_dig = rd_data[7:4];
            st_next.bot_dig = rd_data[3:0];
            st_next.digit_err = (rd_data[7:4] > OPRF_BCD_MAX) || (rd_data[3:0] > OPRF_BCD_MAX);
            st_next.rsp_data = oprf_mask(rd_data, OPRF_SZ_BYTE);
          end
          default: begin
            // address source by word or long
            st_next.rsp_data = oprf_mask(rd_data, st_reg.size);
          end
        endcase
      end
      OPRF_ST_MEM: begin
        // wait for the sequencer; an odd word or long address comes back as an error
        if (link.bs_done) begin
          st_next.st = OPRF_ST_IDLE;
          st_next.ready = 1'b1;
          st_next.rsp_valid = 1'b1;
          st_next.addr_err = link.bs_err;
          st_next.rsp_data = link.bs_rdata;
        end
      end
      default: begin
        st_next.st = OPRF_ST_IDLE;
        st_next.ready = 1'b1;
      end
    endcase
  end

  // state register, ready comes up with reset
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      st_reg <= '0;
      st_reg.ready <= OPRF_RST_READY;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign cmd_ready_out = st_reg.ready;
  assign rsp_valid_out = st_reg.rsp_valid;
  assign rsp_data_out = st_reg.rsp_data;
  assign size_err_out = st_reg.size_err;
  assign addr_err_out = st_reg.addr_err;
  assign branch_out = st_reg.branch;
  assign top_decimal_digit_out = st_reg.top_dig;
  assign bottom_decimal_digit_out = st_reg.bot_dig;
  assign digit_err_out = st_reg.digit_err;

  oprf_regmem u_regmem (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .rf(link.rf_mem)
  );

  // memory sequencer owns the bus pins and registers them
  oprf_bus_seq u_bus_seq (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .bs(link.bs_seq),
    .mem_ack_in(mem_ack_in),
    .mem_rdata_in(mem_rdata_in),
    .mem_req_out(mem_req_out),
    .mem_we_out(mem_we_out),
    .mem_addr_out(mem_addr_out),
    .upper_byte_strobe_out(upper_byte_strobe_out),
    .lower_byte_strobe_out(lower_byte_strobe_out),
    .mem_wdata_out(mem_wdata_out)
  );

  // checks on the core's own behaviour
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!resetn_in);

  AST_SPARE_SIZE: assert property (
    cmd_fire && cmd_size_in == OPRF_SZ_BAD && cmd_op_in == OPRF_OP_READ |=> size_err_out && rsp_valid_out)
    else $error("spare size code not refused");

  AST_AREG_NO_BYTE: assert property (
    cmd_fire && cmd_areg && cmd_size_in == OPRF_SZ_BYTE && cmd_op_in == OPRF_OP_WRITE
    |-> !link.rf_we ##1 size_err_out)
    else $error("byte write to address register accepted");

  AST_DREG_LOW_LANE: assert property (
    st_reg.st == OPRF_ST_IDLE && link.rf_we && !link.rf_widx[OPRF_AREG_BIT] && cmd_op_in == OPRF_OP_WRITE
    && cmd_size_in == OPRF_SZ_BYTE |-> link.rf_be == 4'h1)
    else $error("byte write touched upper lanes");

  AST_AREG_FULL: assert property (
    link.rf_we && link.rf_widx[OPRF_AREG_BIT] |-> link.rf_be == 4'hf)
    else $error("address register written partly");

  AST_AREG_SEXT: assert property (
    st_reg.st == OPRF_ST_IDLE && link.rf_we && cmd_areg && cmd_size_in == OPRF_SZ_WORD
    |-> link.rf_wdata[31:16] == {16{cmd_data_in[15]}})
    else $error("word to address register not sign-extended");

  AST_QUICK_LOAD: assert property (
    cmd_fire && cmd_op_in == OPRF_OP_QUICK && !cmd_bad
    |=> rsp_valid_out && rsp_data_out == {{24{$past(cmd_data_in[7])}}, $past(cmd_data_in[7:0])})
    else $error("quick load value wrong");

  AST_BYTE_READ: assert property (
    cmd_fire && cmd_op_in == OPRF_OP_READ && !cmd_bad && cmd_size_in == OPRF_SZ_BYTE
    |=> !rsp_valid_out ##1 rsp_valid_out && rsp_data_out[31:8] == 24'h0)
    else $error("byte read leaked upper bits");

  AST_AREG_WORD_READ: assert property (
    cmd_fire && cmd_op_in == OPRF_OP_READ && cmd_areg && cmd_size_in == OPRF_SZ_WORD
    |=> ##1 rsp_valid_out && rsp_data_out[31:16] == 16'h0)
    else $error("address word read not low word");

  AST_LOOP_STEP: assert property (
    cmd_fire && cmd_op_in == OPRF_OP_LOOP && !cmd_bad && !cmd_cond_in
    |=> link.rf_we && link.rf_be == 4'h3 ##1 rsp_valid_out && branch_out == (rsp_data_out[15:0] != 16'hffff))
    else $error("loop decrement or branch wrong");

  AST_BCD_SPLIT: assert property (
    rsp_valid_out && st_reg.op == OPRF_OP_BCD && !size_err_out
    |-> top_decimal_digit_out == rsp_data_out[7:4] && bottom_decimal_digit_out == rsp_data_out[3:0])
    else $error("decimal digits misplaced");

  AST_ODD_TRAP: assert property (
    cmd_fire && cmd_op_in == OPRF_OP_MRD && cmd_size_in == OPRF_SZ_WORD && cmd_addr_in[0]
    |=> !mem_req_out ##1 rsp_valid_out && addr_err_out && !mem_req_out)
    else $error("odd word access not trapped");

  AST_EVEN_BEAT: assert property (
    mem_req_out && upper_byte_strobe_out && lower_byte_strobe_out |-> !mem_addr_out[0])
    else $error("word beat at odd address");

  AST_LONG_SECOND: assert property (
    mem_req_out && mem_ack_in && u_bus_seq.s_reg.st == 2'h1 && u_bus_seq.s_reg.size == OPRF_SZ_LONG
    |=> mem_req_out && mem_addr_out == $past(mem_addr_out) + 24'h2)
    else $error("second word of long not at n plus two");

  COV_LOOP_TAKEN: cover property (rsp_valid_out && branch_out);
  COV_LONG_READ: cover property (rsp_valid_out && st_reg.op == OPRF_OP_MRD && st_reg.size == OPRF_SZ_LONG);
  COV_ODD_TRAP: cover property (addr_err_out);
  COV_BYTE_LANE: cover property (mem_req_out && lower_byte_strobe_out && !upper_byte_strobe_out);
endmodule

// File: test/oprf_mem_model.sv
// word-wide memory partner with byte strobes and random stalls
`timescale 1ns/1ps
module oprf_mem_model (
  input wire logic clk_in,
  input wire logic req_in,
  input wire logic we_in,
  input wire logic [23:0] addr_in,
  input wire logic ubs_in,
  input wire logic lbs_in,
  input wire logic [15:0] wdata_in,
  input wire logic slow_in,
  output logic ack_out,
  output logic [15:0] rdata_out
);
  logic [15:0] wm [0:63];
  int w = 0;
  initial begin
    ack_out = 1'b0;
    rdata_out = 16'h0000;
    foreach (wm[i]) wm[i] = 16'h0000;
  end
  // one beat per ack; slow mode stalls up to three cycles
  always @(posedge clk_in) begin
    #1;
    if (ack_out) begin
      ack_out = 1'b0;
      rdata_out = ~rdata_out; // released bus must not look valid
    end else if (req_in && w > 0) begin
      w--;
    end else if (req_in) begin
      if (we_in && ubs_in) wm[addr_in[6:1]][15:8] = wdata_in[15:8];
      if (we_in && lbs_in) wm[addr_in[6:1]][7:0] = wdata_in[7:0];
      rdata_out = wm[addr_in[6:1]];
      ack_out = 1'b1;
      w = slow_in ? $urandom % 4 : 0;
    end
  end
endmodule

// File: test/oprf_core_test.sv
// random commands against a register and byte memory model
`timescale 1ns/1ps
module oprf_core_test;
  import oprf_pkg::*;
  logic ref_clk_in = 0, resetn_in = 0, cmd_valid_in = 0, cmd_cond_in = 0, slow = 0, ack;
  oprf_op_t op = OPRF_OP_NOP;
  oprf_size_t sz = OPRF_SZ_BYTE;
  oprf_loc_t loc = OPRF_LOC_FIELD;
  logic [3:0] rg = 0, ix, tdd, bdd;
  logic [5:0] ea = 0;
  logic [31:0] dat = 0, ex, rsp, rm [0:15];
  logic [23:0] ad = 0, maddr;
  logic [7:0] bm [0:127];
  logic [15:0] mrd, mwd, c;
  logic rdy, rv, se_o, ae_o, br_o, de_o, mreq, mwe, ubs, lbs, se, ae, br;
  int error_cnt = 0, compares = 0, k, n;
  always #50 ref_clk_in = ~ref_clk_in;
  oprf_core dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .cmd_valid_in(cmd_valid_in),
    .cmd_op_in(op), .cmd_size_in(sz), .cmd_loc_in(loc), .cmd_reg_in(rg), .cmd_ea_in(ea),
    .cmd_data_in(dat), .cmd_addr_in(ad), .cmd_cond_in(cmd_cond_in), .mem_ack_in(ack),
    .mem_rdata_in(mrd), .cmd_ready_out(rdy), .rsp_valid_out(rv), .rsp_data_out(rsp),
    .size_err_out(se_o), .addr_err_out(ae_o), .branch_out(br_o), .top_decimal_digit_out(tdd),
    .bottom_decimal_digit_out(bdd), .digit_err_out(de_o), .mem_req_out(mreq), .mem_we_out(mwe),
    .mem_addr_out(maddr), .upper_byte_strobe_out(ubs), .lower_byte_strobe_out(lbs), .mem_wdata_out(mwd));
  oprf_mem_model u_mem (.clk_in(ref_clk_in), .req_in(mreq), .we_in(mwe), .addr_in(maddr), .ubs_in(ubs),
    .lbs_in(lbs), .wdata_in(mwd), .slow_in(slow), .ack_out(ack), .rdata_out(mrd));
  function automatic logic [31:0] mask(oprf_size_t s);
    return s == OPRF_SZ_BYTE ? 32'h000000ff : s == OPRF_SZ_WORD ? 32'h0000ffff : 32'hffffffff;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: op %0d got %h expected %h", $time, op, g, e);
    end
  endtask
  task automatic test_done();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one command, bounded wait, then model update and compare
  task automatic run();
    se = 0; ae = 0; br = 0; ex = 0;
    ix = loc == OPRF_LOC_IMPL ? OPRF_SP_IDX : loc == OPRF_LOC_EA ? {ea[5:3] == OPRF_EA_AREG, ea[2:0]} : rg;
    @(posedge ref_clk_in) #1 cmd_valid_in = 1;
    @(posedge ref_clk_in) #1 cmd_valid_in = 0;
    for (k = 0; k < 100 && rv !== 1'b1; k++) @(posedge ref_clk_in) #1;
    if (k == 100) begin
      error_cnt++;
      test_done();
    end
    n = sz == OPRF_SZ_BYTE ? 1 : sz == OPRF_SZ_WORD ? 2 : 4;
    case (op)
      OPRF_OP_READ, OPRF_OP_WRITE: begin
        se = sz == OPRF_SZ_BAD || (ix[3] && sz == OPRF_SZ_BYTE);
        if (!se && op == OPRF_OP_READ) ex = rm[ix] & mask(sz);
        else if (!se) begin
          rm[ix] = ix[3] ? (sz == OPRF_SZ_WORD ? {{16{dat[15]}}, dat[15:0]} : dat)
            : (rm[ix] & ~mask(sz)) | (dat & mask(sz));
          ex = ix[3] ? rm[ix] : dat & mask(sz); // write answers with the stored operand
        end
      end
      OPRF_OP_QUICK, OPRF_OP_LOOP, OPRF_OP_BCD: begin
        se = ix[3];
        if (!se && op == OPRF_OP_QUICK) rm[ix] = {{24{dat[7]}}, dat[7:0]};
        if (!se && op == OPRF_OP_QUICK) ex = rm[ix];
        if (!se && op == OPRF_OP_LOOP && !cmd_cond_in) begin
          c = rm[ix][15:0] - 16'h0001;
          rm[ix][15:0] = c;
          br = c != OPRF_LOOP_END;
          chk(rsp[15:0], c);
        end
        if (op == OPRF_OP_LOOP) chk(br_o, br);
        if (!se && op == OPRF_OP_BCD) begin
          chk({tdd, bdd}, rm[ix][7:0]);
          chk(de_o, rm[ix][7:4] > 4'h9 || rm[ix][3:0] > 4'h9);
        end
      end
      OPRF_OP_MRD, OPRF_OP_MWR: begin
        ae = ad[0] && sz != OPRF_SZ_BYTE;
        for (k = 0; k < n && !ae; k++) begin
          if (op == OPRF_OP_MWR) bm[ad + k] = dat >> (8 * (n - 1 - k));
          ex = {ex[23:0], bm[ad + k]}; // write beats return the word just stored
        end
      end
      default: ;
    endcase
    chk(se_o, se);
    chk(ae_o, ae);
    if (!ae && (op == OPRF_OP_READ || op == OPRF_OP_WRITE || op == OPRF_OP_QUICK || op == OPRF_OP_MRD
      || op == OPRF_OP_MWR || se))
      chk(rsp, ex);
  endtask
  initial begin
    void'($urandom(85));
    foreach (rm[i]) rm[i] = 32'h00000000;
    foreach (bm[i]) bm[i] = 8'h00;
    repeat (4) @(posedge ref_clk_in);
    #1 resetn_in = 1;
    chk({rdy, rv}, 2'b10);
    // random mix of every op, size, operand location and stall
    for (int i = 0; i < 800; i++) begin
      op = oprf_op_t'($urandom % 8);
      sz = oprf_size_t'($urandom % 4);
      if (sz == OPRF_SZ_BAD && (op == OPRF_OP_MRD || op == OPRF_OP_MWR)) sz = OPRF_SZ_LONG;
      loc = oprf_loc_t'($urandom % 3);
      rg = $urandom;
      ea = $urandom;
      dat = $urandom % 4 ? $urandom : 32'h00000000; // zero low word forces loop wrap
      ad = $urandom & 24'h00003f;
      cmd_cond_in = $urandom % 4 == 0;
      slow = $urandom;
      run();
    end
    test_done();
  end
endmodule
